// file: irq_pkg.sv
// Package: register offsets, field positions, reset values, timing for the
// interrupt flag and edge control block.
// Assumes a 100 MHz aclk and a 32-bit AXI4-Lite register bus.
package irq_pkg;
  // ==========================================================================
  // Register byte offsets
  localparam logic [5:0] OFS_HALL_EDGE   = 6'h00;
  localparam logic [5:0] OFS_EXT_EDGE    = 6'h04;
  localparam logic [5:0] OFS_CTRL_A      = 6'h08;
  localparam logic [5:0] OFS_CTRL_B      = 6'h0c;
  localparam logic [5:0] OFS_CTRL_C      = 6'h10;
  localparam logic [5:0] OFS_CTRL_D      = 6'h14;
  localparam logic [5:0] OFS_GRP_HALL    = 6'h18;
  localparam logic [5:0] OFS_GRP_CAPADC  = 6'h1c;
  localparam logic [5:0] OFS_GRP_PWM     = 6'h20;
  localparam logic [5:0] OFS_GRP_TMR2    = 6'h24;
  localparam logic [5:0] OFS_GRP_TMR0    = 6'h28;
  localparam logic [5:0] OFS_GRP_TMR1    = 6'h2c;
  localparam logic [5:0] OFS_GRP_TMR3TW  = 6'h30;
  localparam logic [5:0] OFS_LOW_SUPPLY  = 6'h34;
  // ==========================================================================
  // Field positions
  localparam int HALL_SRC_BIT    = 6;
  localparam int HALL_C_LSB      = 4;
  localparam int HALL_B_LSB      = 2;
  localparam int HALL_A_LSB      = 0;
  localparam int EXT_EDGE_LSB    = 0;
  localparam int GLOBAL_EN_BIT   = 0;
  localparam int CMP0_FLAG_BIT   = 6;
  localparam int CMP0_EN_BIT     = 3;
  localparam int EXT_FLAG_BIT    = 5;
  localparam int EXT_EN_BIT      = 2;
  localparam int GRP0_FLAG_BIT   = 4;
  localparam int GRP0_EN_BIT     = 1;
  localparam int OC_FLAG_BIT     = 7;
  localparam int LS_FLAG_BIT     = 6;
  localparam int GRP1_FLAG_BIT   = 5;
  localparam int NF_FLAG_BIT     = 4;
  localparam int LS_OUT_BIT      = 5;
  localparam int LS_ON_BIT       = 4;
  // Writable masks (unimplemented bits read zero)
  localparam logic [7:0] MASK_HALL_EDGE = 8'h7f;
  localparam logic [7:0] MASK_EXT_EDGE  = 8'h03;
  localparam logic [7:0] MASK_CTRL_A    = 8'h7f;
  localparam logic [7:0] MASK_FULL      = 8'hff;
  localparam logic [7:0] MASK_GRP_HALL  = 8'h77;
  localparam logic [7:0] MASK_GRP_PAIR  = 8'h33;
  localparam logic [7:0] MASK_GRP_TW    = 8'h77;
  localparam logic [7:0] MASK_LOW_SUP   = 8'h17;
  localparam logic [7:0] RESET_VALUE    = 8'h00;
  // Edge codes
  localparam logic [1:0] EDGE_OFF  = 2'h0;
  localparam logic [1:0] EDGE_RISE = 2'h1;
  localparam logic [1:0] EDGE_FALL = 2'h2;
  localparam logic [1:0] EDGE_BOTH = 2'h3;
  // Threshold codes
  localparam logic [2:0] THR_3V3 = 3'h5;
  localparam logic [2:0] THR_3V6 = 3'h6;
  localparam logic [2:0] THR_4V0 = 3'h7;
  // ==========================================================================
  // Timing
  localparam int CLK_PERIOD_NS    = 10;
  localparam int LOW_SUP_DELAY_NS = 150;
  localparam int LOW_SUP_DELAY_CYC =
    (LOW_SUP_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [1:0] AXI_OKAY   = 2'h0;
  localparam logic [1:0] AXI_SLVERR = 2'h2;
endpackage

// file: irq_flag_edge.sv
// Interrupt flag and edge control: edge selection, request flags, enables,
// grouped vectors and low-supply detector interrupt, on AXI4-Lite.
// Assumes synchronous inputs on aclk and a CPU that takes cpu_irq_req.
// Function
// - Hall source bit picks Hall pins (0) or comparators 1-3 (1).
// - Hall C edge field: off, rising, falling, both edges.
// - Hall B edge field with the same coding.
// - Hall A edge field with the same coding.
// - External pin edge field: never, rising, falling, either edge.
// - Unimplemented register bits read back as zero.
// - Global enable bit 0 gates every request on cpu_irq_req; idle_wake is not gated by it.
// - Comparator 0 flag bit 6, enable bit 3 of control A.
// - External pin flag bit 5, enable bit 2, set by selected edge.
// - Group 0 flag bit 4, enable bit 1 of control A.
// - Control B holds overcurrent, low-supply, group 1, filter flags and enables.
// - Each source except primary_d_events[2] and group_c_events[2] has enable and flag; grouped sources share one vector.
// - Low-supply flag sets only after a fixed delay of output high.
// - In sleep the low-supply detector is forced off.
// - Pending low-supply request wakes from idle; software presets flag to avoid.
// - Threshold codes 101, 110, 111 select 3.3V, 3.6V, 4.0V; others reserved.
// - Flags and enables follow a type, number, E or F naming pattern.
`timescale 1ns/1ns
`default_nettype none
module irq_flag_edge
  import irq_pkg::*;
#(
  parameter int LS_DELAY = LOW_SUP_DELAY_CYC
) (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic        clk_en,
  input  wire logic [5:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [5:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic [2:0]  hall_pin,
  input  wire logic [2:0]  analog_comparator,
  input  wire logic        ext_pin,
  input  wire logic        comparator0_event,
  input  wire logic        overcurrent_event,
  input  wire logic        filtered_input_event,
  input  wire logic        low_supply_raw,
  input  wire logic [3:0]  primary_d_events,
  input  wire logic [3:0]  capadc_events,
  input  wire logic [3:0]  pwm_events,
  input  wire logic [1:0]  tmr2_events,
  input  wire logic [1:0]  tmr0_events,
  input  wire logic [1:0]  tmr1_events,
  input  wire logic [2:0]  tmr3tw_events,
  input  wire logic [2:0]  group_c_events,
  input  wire logic        sleep_mode,
  input  wire logic        idle_mode,
  output logic             cpu_irq_req,
  output logic             idle_wake,
  output logic             low_supply_detector_on,
  output logic [2:0]       low_supply_threshold_sel
);

  // ==========================================================================
  // Edge decode shared by Hall lines and external pin
  function automatic logic edge_hit(input logic [1:0] sel, input logic cur,
                                    input logic prev);
    unique case (sel)
      EDGE_OFF:  edge_hit = 1'b0;
      EDGE_RISE: edge_hit = cur & ~prev;
      EDGE_FALL: edge_hit = ~cur & prev;
      EDGE_BOTH: edge_hit = cur ^ prev;
    endcase
  endfunction

  // Register storage
  logic [7:0] hall_edge_q, ext_edge_q, ctrl_a_q, ctrl_b_q, ctrl_c_q, ctrl_d_q;
  logic [7:0] grp_hall_q, grp_capadc_q, grp_pwm_q, grp_tmr2_q, grp_tmr0_q;
  logic [7:0] grp_tmr1_q, grp_tmr3tw_q, low_sup_q;
  logic [2:0] hall_prev_q;
  logic       ext_prev_q, ls_out_prev_q;
  logic [15:0] ls_cnt_q;

  // ==========================================================================
  // AXI4-Lite write channel
  logic       aw_held_q, w_held_q;
  logic [5:0] aw_addr_q;
  logic [31:0] w_data_q;
  logic [3:0] w_strb_q;
  logic       wr_fire;
  logic       wr_hit;
  assign wr_fire = aw_held_q & w_held_q & ~s_axi_bvalid;

  // Capture address and data in either order
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_q     <= 1'b0;
      w_held_q      <= 1'b0;
      aw_addr_q     <= 6'h00;
      w_data_q      <= 32'h0;
      w_strb_q      <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= AXI_OKAY;
    end else if (clk_en) begin
      s_axi_awready <= ~aw_held_q & ~s_axi_awready & s_axi_awvalid;
      s_axi_wready  <= ~w_held_q & ~s_axi_wready & s_axi_wvalid;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held_q <= 1'b1;
        aw_addr_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held_q <= 1'b1;
        w_data_q <= s_axi_wdata;
        w_strb_q <= s_axi_wstrb;
      end
      if (wr_fire) begin
        aw_held_q    <= 1'b0;
        w_held_q     <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_hit ? AXI_OKAY : AXI_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  logic       wr_lane;
  logic [7:0] wr_byte;
  assign wr_lane = wr_fire & w_strb_q[0];
  assign wr_byte = w_data_q[7:0];
  assign wr_hit  = (aw_addr_q <= OFS_LOW_SUPPLY) && (aw_addr_q[1:0] == 2'h0);

  // Write strobe per register
  function automatic logic wsel(input logic [5:0] ofs);
    wsel = wr_lane && (aw_addr_q == ofs);
  endfunction

  // ==========================================================================
  // Edge sources
  logic [2:0] hall_src;
  logic [2:0] hall_hit;
  logic       ext_hit;
  assign hall_src = hall_edge_q[HALL_SRC_BIT] ? analog_comparator : hall_pin;
  assign hall_hit[2] = edge_hit(hall_edge_q[HALL_C_LSB +: 2], hall_src[2],
                                hall_prev_q[2]);
  assign hall_hit[1] = edge_hit(hall_edge_q[HALL_B_LSB +: 2], hall_src[1],
                                hall_prev_q[1]);
  assign hall_hit[0] = edge_hit(hall_edge_q[HALL_A_LSB +: 2], hall_src[0],
                                hall_prev_q[0]);
  assign ext_hit = edge_hit(ext_edge_q[EXT_EDGE_LSB +: 2], ext_pin, ext_prev_q);

  // Previous levels for edge detection
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      hall_prev_q   <= 3'h0;
      ext_prev_q    <= 1'b0;
      ls_out_prev_q <= 1'b0;
    end else if (clk_en) begin
      hall_prev_q   <= hall_src;
      ext_prev_q    <= ext_pin;
      ls_out_prev_q <= low_sup_q[LS_OUT_BIT];
    end
  end

  // Config registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      hall_edge_q <= RESET_VALUE;
      ext_edge_q  <= RESET_VALUE;
    end else if (clk_en) begin
      if (wsel(OFS_HALL_EDGE)) hall_edge_q <= wr_byte & MASK_HALL_EDGE;
      if (wsel(OFS_EXT_EDGE))  ext_edge_q  <= wr_byte & MASK_EXT_EDGE;
    end
  end

  // ==========================================================================
  // Group (multi-function) registers: upper nibble flags, lower enables;
  // hardware sets, only software clears, set wins
  function automatic logic [7:0] grp_next(input logic [7:0] cur, input logic we,
                                          input logic [3:0] ev,
                                          input logic [7:0] mask);
    logic [7:0] v;
    v = we ? wr_byte : cur;
    v[7:4] = v[7:4] | ev;
    grp_next = v & mask;
  endfunction

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      grp_hall_q   <= RESET_VALUE;
      grp_capadc_q <= RESET_VALUE;
      grp_pwm_q    <= RESET_VALUE;
      grp_tmr2_q   <= RESET_VALUE;
      grp_tmr0_q   <= RESET_VALUE;
      grp_tmr1_q   <= RESET_VALUE;
      grp_tmr3tw_q <= RESET_VALUE;
    end else if (clk_en) begin
      grp_hall_q   <= grp_next(grp_hall_q, wsel(OFS_GRP_HALL),
                               {1'b0, hall_hit}, MASK_GRP_HALL);
      grp_capadc_q <= grp_next(grp_capadc_q, wsel(OFS_GRP_CAPADC), capadc_events,
                               MASK_FULL);
      grp_pwm_q    <= grp_next(grp_pwm_q, wsel(OFS_GRP_PWM), pwm_events, MASK_FULL);
      grp_tmr2_q   <= grp_next(grp_tmr2_q, wsel(OFS_GRP_TMR2),
                               {2'h0, tmr2_events}, MASK_GRP_PAIR);
      grp_tmr0_q   <= grp_next(grp_tmr0_q, wsel(OFS_GRP_TMR0),
                               {2'h0, tmr0_events}, MASK_GRP_PAIR);
      grp_tmr1_q   <= grp_next(grp_tmr1_q, wsel(OFS_GRP_TMR1),
                               {2'h0, tmr1_events}, MASK_GRP_PAIR);
      grp_tmr3tw_q <= grp_next(grp_tmr3tw_q, wsel(OFS_GRP_TMR3TW),
                               {1'b0, tmr3tw_events}, MASK_GRP_TW);
    end
  end

  // Group pending: any enabled sub-source flag
  function automatic logic grp_any(input logic [7:0] r);
    grp_any = |(r[7:4] & r[3:0]);
  endfunction

  // ==========================================================================
  // Low-supply detector: forced off in sleep, delayed flag
  logic ls_active;
  logic ls_set;
  assign ls_active = low_sup_q[LS_ON_BIT] & ~sleep_mode;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      low_sup_q <= RESET_VALUE;
      ls_cnt_q  <= 16'h0;
    end else if (clk_en) begin
      if (wsel(OFS_LOW_SUPPLY))
        low_sup_q[4:0] <= wr_byte[4:0] & MASK_LOW_SUP[4:0];
      low_sup_q[LS_OUT_BIT] <= ls_active & low_supply_raw;
      if (!low_sup_q[LS_OUT_BIT])
        ls_cnt_q <= 16'h0;
      else if (ls_cnt_q != LS_DELAY[15:0])
        ls_cnt_q <= ls_cnt_q + 16'h1;
    end
  end
  assign ls_set = low_sup_q[LS_OUT_BIT] && (ls_cnt_q == LS_DELAY[15:0] - 16'h1);

  // ==========================================================================
  // Primary control registers: set wins over a software clear
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_a_q <= RESET_VALUE;
      ctrl_b_q <= RESET_VALUE;
      ctrl_c_q <= RESET_VALUE;
      ctrl_d_q <= RESET_VALUE;
    end else if (clk_en) begin
      ctrl_a_q <= ((wsel(OFS_CTRL_A) ? wr_byte : ctrl_a_q)
                   | {1'b0, comparator0_event, ext_hit,
                      grp_any(grp_hall_q), 4'h0}) & MASK_CTRL_A;
      ctrl_b_q <= (wsel(OFS_CTRL_B) ? wr_byte : ctrl_b_q)
                  | {overcurrent_event, ls_set,
                     grp_any(grp_capadc_q), filtered_input_event, 4'h0};
      ctrl_c_q <= (wsel(OFS_CTRL_C) ? wr_byte : ctrl_c_q)
                  | {grp_any(grp_tmr1_q), grp_any(grp_tmr0_q),
                     grp_any(grp_tmr2_q), grp_any(grp_pwm_q), 4'h0};
      ctrl_d_q <= (wsel(OFS_CTRL_D) ? wr_byte : ctrl_d_q)
                  | {primary_d_events[3], grp_any(grp_tmr3tw_q),
                     primary_d_events[1:0] | group_c_events[1:0], 4'h0};
    end
  end

  // ==========================================================================
  // CPU request and idle wake
  logic any_pending;
  // Control A pairs flags 6..4 with enables 3..1; bit 0 is the global enable
  assign any_pending = |(ctrl_a_q[6:4] & ctrl_a_q[3:1])
                     | |(ctrl_b_q[7:4] & ctrl_b_q[3:0])
                     | |(ctrl_c_q[7:4] & ctrl_c_q[3:0])
                     | |(ctrl_d_q[7:4] & ctrl_d_q[3:0]);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cpu_irq_req              <= 1'b0;
      idle_wake                <= 1'b0;
      low_supply_detector_on   <= 1'b0;
      low_supply_threshold_sel <= 3'h0;
    end else if (clk_en) begin
      cpu_irq_req <= ctrl_a_q[GLOBAL_EN_BIT] & any_pending;
      idle_wake   <= idle_mode & ls_set & ~ctrl_b_q[LS_FLAG_BIT];
      low_supply_detector_on   <= ls_active;
      low_supply_threshold_sel <= low_sup_q[2:0];
    end
  end

  // ==========================================================================
  // AXI4-Lite read channel
  logic [7:0] rd_byte;
  logic       rd_hit;
  always_comb begin
    rd_hit  = 1'b1;
    rd_byte = 8'h00;
    unique case (s_axi_araddr)
      OFS_HALL_EDGE:  rd_byte = hall_edge_q;
      OFS_EXT_EDGE:   rd_byte = ext_edge_q;
      OFS_CTRL_A:     rd_byte = ctrl_a_q;
      OFS_CTRL_B:     rd_byte = ctrl_b_q;
      OFS_CTRL_C:     rd_byte = ctrl_c_q;
      OFS_CTRL_D:     rd_byte = ctrl_d_q;
      OFS_GRP_HALL:   rd_byte = grp_hall_q;
      OFS_GRP_CAPADC: rd_byte = grp_capadc_q;
      OFS_GRP_PWM:    rd_byte = grp_pwm_q;
      OFS_GRP_TMR2:   rd_byte = grp_tmr2_q;
      OFS_GRP_TMR0:   rd_byte = grp_tmr0_q;
      OFS_GRP_TMR1:   rd_byte = grp_tmr1_q;
      OFS_GRP_TMR3TW: rd_byte = grp_tmr3tw_q;
      OFS_LOW_SUPPLY: rd_byte = low_sup_q;
      default:        rd_hit  = 1'b0;
    endcase
  end

  // One read at a time, answer one cycle after address taken
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0;
      s_axi_rresp   <= AXI_OKAY;
    end else if (clk_en) begin
      s_axi_arready <= s_axi_arvalid & ~s_axi_arready & ~s_axi_rvalid;
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= {24'h0, rd_byte};
        s_axi_rresp  <= rd_hit ? AXI_OKAY : AXI_SLVERR;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // ==========================================================================
  // Checks
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  global_gate_a: assert property (clk_en && !ctrl_a_q[GLOBAL_EN_BIT] ##1 clk_en
                                  |-> !cpu_irq_req)
    else $error("request passed with global enable off");
  cmp0_req_a: assert property (clk_en && ctrl_a_q[0] && ctrl_a_q[6] && ctrl_a_q[3]
                               ##1 clk_en |-> cpu_irq_req)
    else $error("comparator 0 request missed");
  ext_rise_a: assert property (clk_en && ext_edge_q[1:0] == EDGE_RISE && ext_pin
                               && !ext_prev_q |=> ctrl_a_q[EXT_FLAG_BIT])
    else $error("external rising edge not flagged");
  ext_off_a: assert property (clk_en && ext_edge_q[1:0] == EDGE_OFF && !ctrl_a_q[5]
                              && !(wr_lane && aw_addr_q == OFS_CTRL_A) |=> !ctrl_a_q[5])
    else $error("external flag set while disabled");
  hall_src_a: assert property (clk_en && hall_edge_q[6] && hall_edge_q[1:0] == EDGE_BOTH
                               && analog_comparator[0] != hall_prev_q[0]
                               |=> grp_hall_q[4])
    else $error("comparator hall edge not flagged");
  grp_sticky_a: assert property (clk_en && grp_hall_q[4]
                                 && !(wr_lane && aw_addr_q == OFS_GRP_HALL)
                                 |=> grp_hall_q[4])
    else $error("group flag cleared by hardware");
  sleep_off_a: assert property (clk_en && sleep_mode |=> !low_supply_detector_on)
    else $error("detector on during sleep");
  unimpl_zero_a: assert property (ext_edge_q[7:2] == 6'h0 && hall_edge_q[7] == 1'b0)
    else $error("unimplemented bits nonzero");
  ls_delay_a: assert property ($rose(low_sup_q[LS_OUT_BIT]) |-> !ls_set)
    else $error("low-supply flag set without delay");

  wr_cov_c:   cover property (s_axi_bvalid && s_axi_bready);
  rd_cov_c:   cover property (s_axi_rvalid && s_axi_rready);
  irq_cov_c:  cover property (cpu_irq_req);
  wake_cov_c: cover property (idle_wake);

endmodule // irq_flag_edge
`default_nettype wire

// file: cpu_model.sv
// CPU side model: enters idle when asked, leaves idle on a wake pulse.
// Assumes idle_wake is a one-cycle pulse on aclk.
`timescale 1ns/1ns
`default_nettype none
module cpu_model (
  input  wire logic aclk,
  input  wire logic aresetn,
  input  wire logic go_idle,
  input  wire logic idle_wake,
  output logic      idle_mode,
  output int        wakes
);
  // ==========================================================================
  // Power state and wake counter
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      idle_mode <= 1'b0;
      wakes     <= 0;
    end else if (idle_wake) begin
      idle_mode <= 1'b0;
      wakes     <= wakes + 1;
    end else if (go_idle) begin
      idle_mode <= 1'b1;
    end
  end
endmodule // cpu_model
`default_nettype wire

// file: tb.sv
// Testbench: register access, edge triggers, request gating, low supply.
// Assumes irq_pkg, irq_flag_edge and cpu_model are compiled first.
`timescale 1ns/1ns
`default_nettype none
module tb
  import irq_pkg::*;
;
  localparam int LSD = 3;
  logic aclk, aresetn, clk_en, go_idle, lv, awvalid, wvalid, bready, arvalid, rready;
  logic comparator0_event, overcurrent_event, filtered_input_event, low_supply_raw, sleep_mode;
  logic [3:0] primary_d_events, capadc_events, pwm_events, wstrb;
  logic [1:0] tmr2_events, tmr0_events, tmr1_events;
  logic [2:0] tmr3tw_events, group_c_events;
  logic [5:0] awaddr, araddr;
  logic [31:0] wdata, seed, d;
  logic [33:0] got;
  logic [33:0] sb[$];
  logic [7:0] msk [14] = '{8'h7f, 8'h03, 8'h7f, 8'hff, 8'hff, 8'hff, 8'h77,
                           8'hff, 8'hff, 8'h33, 8'h33, 8'h33, 8'h77, 8'h17};
  wire awready, wready, bvalid, arready, rvalid, ext_pin, idle_mode, cpu_irq_req, idle_wake;
  wire low_supply_detector_on;
  wire [1:0] bresp, rresp;
  wire [31:0] rdata;
  wire [2:0] hall_pin, analog_comparator, low_supply_threshold_sel;
  int wakes, src, n_mismatch = 0, comparisons = 0;

  // ==========================================================================
  // Design, CPU model and pin routing
  irq_flag_edge #(.LS_DELAY(LSD)) DUT (
    .aclk, .aresetn, .clk_en,
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .hall_pin, .analog_comparator, .ext_pin, .comparator0_event, .overcurrent_event,
    .filtered_input_event, .low_supply_raw, .primary_d_events, .capadc_events, .pwm_events,
    .tmr2_events, .tmr0_events, .tmr1_events, .tmr3tw_events, .group_c_events,
    .sleep_mode, .idle_mode, .cpu_irq_req, .idle_wake, .low_supply_detector_on,
    .low_supply_threshold_sel
  );
  cpu_model cpu (.aclk, .aresetn, .go_idle, .idle_wake, .idle_mode, .wakes);
  // One level drives the chosen source only
  assign ext_pin = lv && src == 0;
  assign hall_pin = {3{lv && src == 1}};
  assign analog_comparator = {3{lv && src == 2}};

  // ==========================================================================
  // Clock, helpers and bus tasks
  initial begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task automatic cmp(input logic [33:0] e, input logic [33:0] g);
    comparisons++;
    if (g !== e) begin
      n_mismatch++;
      $display("[ERR] t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask
  task automatic cb(input logic e, input logic g);
    cmp({33'h0, e}, {33'h0, g});
  endtask
  task automatic wr(input logic [5:0] a, input logic [31:0] v, input logic [1:0] r = AXI_OKAY);
    bit aw = 1'b1;
    bit w = 1'b1;
    sb.push_back({r, 32'h0});
    @(posedge aclk);
    awaddr <= a;
    wdata <= v;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      aw = aw & ~awready;
      w = w & ~wready;
      awvalid <= aw;
      wvalid <= w;
    end while (aw | w);
    do @(posedge aclk); while (!bvalid);
    bready <= 1'b0;
  endtask
  task automatic rd(input logic [5:0] a, input logic [31:0] e, input logic [1:0] r = AXI_OKAY);
    sb.push_back({r, e});
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge aclk); while (!arready);
    arvalid <= 1'b0;
    do @(posedge aclk); while (!rvalid);
    rready <= 1'b0;
  endtask
  // Rising then falling level on one source, flags read and cleared
  task automatic edge_case(input int which, input logic [7:0] ev, input logic [5:0] ro,
                           input logic [7:0] hr, input logic [7:0] hf);
    src = which;
    wr(which != 0 ? OFS_HALL_EDGE : OFS_EXT_EDGE, {24'h0, ev});
    wr(ro, 32'h0);
    for (int k = 0; k < 2; k++) begin
      lv <= (k == 0);
      repeat (3) @(posedge aclk);
      rd(ro, {24'h0, k != 0 ? hf : hr});
      wr(ro, 32'h0);
    end
  endtask
  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  // ==========================================================================
  // Monitor: each bus answer against the oldest note
  always @(posedge aclk) begin
    if ((bvalid && bready) || (rvalid && rready)) begin
      got = bvalid ? {bresp, 32'h0} : {rresp, rdata};
      cmp(sb.pop_front(), got);
    end
  end
  // Watchdog against a hung handshake
  initial begin
    repeat (20000) @(posedge aclk);
    n_mismatch++;
    give_verdict();
  end

  // ==========================================================================
  // Main sequence
  initial begin
    {aresetn, go_idle, lv, awvalid, wvalid, bready, arvalid, rready, sleep_mode} = '0;
    {comparator0_event, overcurrent_event, filtered_input_event, low_supply_raw} = '0;
    {primary_d_events, capadc_events, pwm_events, tmr2_events, tmr0_events} = '0;
    {tmr1_events, tmr3tw_events, group_c_events, awaddr, araddr, wdata} = '0;
    clk_en = 1'b1;
    wstrb = 4'hf;
    seed = 32'h59;
    src = 0;
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    for (int i = 0; i < 14; i++) rd(6'(4 * i), 32'h0);
    rd(6'h38, 32'h0, AXI_SLVERR);
    wr(6'h38, 32'hff, AXI_SLVERR);
    for (int i = 0; i < 14; i++) begin
      d = rnd();
      wr(6'(4 * i), d);
      rd(6'(4 * i), {24'h0, d[7:0] & msk[i]});
    end
    for (int i = 13; i >= 0; i--) wr(6'(4 * i), 32'h0);
    for (int c = 0; c < 4; c++) begin
      edge_case(0, 8'(c), OFS_CTRL_A, c[0] ? 8'h20 : 8'h00, c[1] ? 8'h20 : 8'h00);
      edge_case(1, {2'b00, c[1:0], c[1:0], c[1:0]}, OFS_GRP_HALL,
                c[0] ? 8'h70 : 8'h00, c[1] ? 8'h70 : 8'h00);
    end
    edge_case(2, 8'h7f, OFS_GRP_HALL, 8'h70, 8'h70);
    edge_case(1, 8'h7f, OFS_GRP_HALL, 8'h00, 8'h00);
    // Group 0 flag in control A follows an enabled Hall A flag
    wr(OFS_GRP_HALL, 32'h01);
    edge_case(1, 8'h01, OFS_CTRL_A, 8'h10, 8'h10);
    wr(OFS_GRP_HALL, 32'h0);
    // Comparator 0 request gated by its enable and the global enable
    wr(OFS_CTRL_A, 32'h08);
    comparator0_event <= 1'b1;
    @(posedge aclk);
    comparator0_event <= 1'b0;
    rd(OFS_CTRL_A, 32'h48);
    cb(1'b0, cpu_irq_req);
    wr(OFS_CTRL_A, 32'h49);
    repeat (3) @(posedge aclk);
    cb(1'b1, cpu_irq_req);
    wr(OFS_CTRL_A, 32'h41);
    repeat (3) @(posedge aclk);
    cb(1'b0, cpu_irq_req);
    wr(OFS_CTRL_A, 32'h0);
    // Control B flags and a grouped source
    wr(OFS_GRP_CAPADC, 32'h01);
    overcurrent_event <= 1'b1;
    filtered_input_event <= 1'b1;
    capadc_events <= 4'h1;
    @(posedge aclk);
    overcurrent_event <= 1'b0;
    filtered_input_event <= 1'b0;
    capadc_events <= 4'h0;
    rd(OFS_CTRL_B, 32'hb0);
    wr(OFS_GRP_CAPADC, 32'h0);
    wr(OFS_CTRL_B, 32'h0);
    wr(OFS_GRP_PWM, 32'h01);
    pwm_events <= 4'h1;
    @(posedge aclk);
    pwm_events <= 4'h0;
    rd(OFS_GRP_PWM, 32'h11);
    rd(OFS_CTRL_C, 32'h10);
    wr(OFS_GRP_PWM, 32'h0);
    rd(OFS_CTRL_C, 32'h10);
    wr(OFS_CTRL_C, 32'h0);
    // Low supply: thresholds, sleep, delayed flag, idle wake
    for (int t = 5; t < 8; t++) begin
      wr(OFS_LOW_SUPPLY, 32'h10 | t);
      repeat (3) @(posedge aclk);
      cmp(34'(t), {31'h0, low_supply_threshold_sel});
      cb(1'b1, low_supply_detector_on);
    end
    sleep_mode <= 1'b1;
    repeat (3) @(posedge aclk);
    cb(1'b0, low_supply_detector_on);
    sleep_mode <= 1'b0;
    go_idle <= 1'b1;
    @(posedge aclk);
    go_idle <= 1'b0;
    low_supply_raw <= 1'b1;
    repeat (2) @(posedge aclk);
    cb(1'b1, idle_mode);
    repeat (LSD + 8) @(posedge aclk);
    cb(1'b0, idle_mode);
    rd(OFS_CTRL_B, 32'h40);
    low_supply_raw <= 1'b0;
    wr(OFS_CTRL_B, 32'h40);
    go_idle <= 1'b1;
    @(posedge aclk);
    go_idle <= 1'b0;
    low_supply_raw <= 1'b1;
    repeat (LSD + 8) @(posedge aclk);
    cmp(34'h1, 34'(wakes));
    give_verdict();
  end
endmodule // tb
`default_nettype wire
